// [pdio_pkg.sv]
// Package for the two-port parallel I/O block with slave port.
// Assumes an 8-bit register bus and a single 50 MHz clock.
package pdio_pkg;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] WIDE_PORT_DATA_OFS = 8'h08;
    localparam logic [7:0] CONTROL_PORT_DATA_OFS = 8'h09;
    localparam logic [7:0] WIDE_PORT_DIRECTION_OFS = 8'h88;
    localparam logic [7:0] SLAVE_PORT_STATUS_CONTROL_OFS = 8'h89;
    localparam logic [7:0] ANALOG_PIN_CONFIG_OFS = 8'h9f;

    // ------------------------------------------------------------
    // Field positions of the status/control register
    // ------------------------------------------------------------
    localparam int INPUT_FULL_BIT = 7;
    localparam int OUTPUT_FULL_BIT = 6;
    localparam int INPUT_OVERFLOW_BIT = 5;
    localparam int SLAVE_MODE_SELECT_BIT = 4;
    localparam int CTRL_DIR_MSB = 2;

    // Control port pin positions
    localparam int READ_STROBE_IDX = 0;
    localparam int WRITE_STROBE_IDX = 1;
    localparam int CHIP_SELECT_IDX = 2;

    // ------------------------------------------------------------
    // Reset values and masks
    // ------------------------------------------------------------
    localparam logic [7:0] WIDE_DIR_RESET = 8'hff;
    localparam logic [2:0] CTRL_DIR_RESET = 3'h7;
    localparam logic [7:0] DATA_RESET = 8'h00;
    localparam logic [2:0] CTRL_DATA_RESET = 3'h0;
    localparam logic [7:0] ANALOG_CFG_RESET = 8'h00;
    // Implemented bits of the analog configuration register
    localparam logic [7:0] ANALOG_CFG_MASK = 8'hcf;
    // Low bits: one digital-enable per control pin, 0 = analog
    localparam int ANALOG_DIGITAL_MSB = 2;

    // Synchronised control pins travel together
    typedef struct packed {
        logic chip_select_n;
        logic write_strobe_n;
        logic read_strobe_n;
    } ctrl_pins_t;

    // Slave-port transfer state
    typedef enum logic [1:0] {
        XFER_IDLE,
        XFER_WRITE,
        XFER_READ
    } xfer_state_t;

endpackage : pdio_pkg

// [parallel_port_d_e_io.sv]
// Wide 8-bit port and 3-bit control port with parallel slave port.
// Assumes a register master on I_MCLK; pins are asynchronous and
// pass two flip-flops before use. Tri-state is resolved outside.
//
// The plain strobed port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module parallel_port_d_e_io (
    // Clock and reset
    input wire logic I_MCLK,
    input wire logic I_RESET,
    // Register bus
    input wire logic [7:0] i_ADDR,
    input wire logic [7:0] i_WDATA,
    input wire logic i_WR,
    input wire logic i_RD,
    output logic [7:0] o_RDATA,
    // Wide port pins
    input wire logic [7:0] i_WIDE_PIN,
    output logic [7:0] o_WIDE_PIN,
    output logic [7:0] o_WIDE_OE,
    // Control port pins
    input wire logic [2:0] i_CTRL_PIN,
    output logic [2:0] o_CTRL_PIN,
    output logic [2:0] o_CTRL_OE
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    // Two-stage synchronisers for the asynchronous pins
    logic [7:0] wide_meta_reg;
    logic [7:0] wide_sync_reg;
    logic [2:0] ctrl_meta_reg;
    logic [2:0] ctrl_sync_reg;

    // Software-visible latches and configuration
    logic [7:0] wide_out_reg;
    logic [7:0] wide_in_reg;
    logic [7:0] wide_dir_reg;
    logic [2:0] ctrl_out_reg;
    logic [2:0] ctrl_dir_reg;
    logic [7:0] analog_cfg_reg;
    logic slave_mode_reg;

    // Slave-port status flags
    logic input_full_reg;
    logic output_full_reg;
    logic overflow_reg;

    // Registered read answer
    logic [7:0] rdata_reg;

    // Transfer tracking on the synchronised strobes
    pdio_pkg::xfer_state_t xfer_reg;
    pdio_pkg::xfer_state_t xfer_next;
    pdio_pkg::ctrl_pins_t strobes;
    logic sel;
    logic wr_active;
    logic rd_active;
    logic write_done;
    logic read_start;

    // Read-side views
    logic [2:0] ctrl_digital;
    logic [2:0] ctrl_read_val;
    logic [7:0] status_val;

    // Register bus qualifiers
    logic cpu_wide_wr;
    logic cpu_wide_rd;
    logic cpu_stat_wr;

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    // Two stages each; only the second stage is read below. The
    // stages carry no reset: they flush within two clocks and a
    // reset term would only add a path into the metastable stage.
    always_ff @(posedge I_MCLK) begin
        wide_meta_reg <= i_WIDE_PIN;
        wide_sync_reg <= wide_meta_reg;
    end

    always_ff @(posedge I_MCLK) begin
        ctrl_meta_reg <= i_CTRL_PIN;
        ctrl_sync_reg <= ctrl_meta_reg;
    end

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    // Register access qualifiers. Only the wide-port data and status addresses
    // have side effects beyond the register itself, so only those
    // get named qualifiers
    assign cpu_wide_wr = i_WR && (i_ADDR == pdio_pkg::WIDE_PORT_DATA_OFS);
    assign cpu_wide_rd = i_RD && (i_ADDR == pdio_pkg::WIDE_PORT_DATA_OFS);
    assign cpu_stat_wr = i_WR &&
        (i_ADDR == pdio_pkg::SLAVE_PORT_STATUS_CONTROL_OFS);

    // ------------------------------------------------------------
    // Slave-port strobe decode
    // ------------------------------------------------------------
    // Strobes use the raw digital level; the analog mask is a read
    // path only, so firmware must set pins digital before enabling
    assign strobes = pdio_pkg::ctrl_pins_t'(ctrl_sync_reg);
    assign sel = slave_mode_reg && !strobes.chip_select_n;
    assign wr_active = sel && !strobes.write_strobe_n;
    assign rd_active = sel && !strobes.read_strobe_n;

    // Transfer tracker: a transfer starts on the first sample with
    // both lines low and ends when either returns high
    // A write and a read that start in the same idle sample are tracked as the write only
    always_comb begin
        xfer_next = xfer_reg;
        unique case (xfer_reg)
            pdio_pkg::XFER_IDLE: begin
                if (wr_active) begin
                    xfer_next = pdio_pkg::XFER_WRITE;
                end else if (rd_active) begin
                    xfer_next = pdio_pkg::XFER_READ;
                end
            end
            pdio_pkg::XFER_WRITE: begin
                if (!wr_active) begin
                    xfer_next = pdio_pkg::XFER_IDLE;
                end
            end
            pdio_pkg::XFER_READ: begin
                if (!rd_active) begin
                    xfer_next = pdio_pkg::XFER_IDLE;
                end
            end
            // The fourth code is unused; recover to idle if ever seen
            default: begin
                xfer_next = pdio_pkg::XFER_IDLE;
            end
        endcase
    end

    always_ff @(posedge I_MCLK) begin
        if (I_RESET) begin
            xfer_reg <= pdio_pkg::XFER_IDLE;
        end else begin
            xfer_reg <= xfer_next;
        end
    end

    // Event pulses derived from the tracker
    // write_done lasts one cycle as the tracker returns to idle;
    // read_start fires only from idle, so a long read clears once
    assign write_done = (xfer_reg == pdio_pkg::XFER_WRITE) && !wr_active;
    assign read_start = (xfer_reg == pdio_pkg::XFER_IDLE) && !wr_active &&
        rd_active;

    // ------------------------------------------------------------
    // Wide port latches
    // ------------------------------------------------------------
    // Output latch written by firmware in either mode
    always_ff @(posedge I_MCLK) begin
        if (I_RESET) begin
            wide_out_reg <= pdio_pkg::DATA_RESET;
        end else if (cpu_wide_wr) begin
            wide_out_reg <= i_WDATA;
        end
    end

    // Input latch follows the pins while the write is held low, so
    // the level kept is the one just before the strobe rises
    always_ff @(posedge I_MCLK) begin
        if (I_RESET) begin
            wide_in_reg <= pdio_pkg::DATA_RESET;
        end else if (wr_active) begin
            wide_in_reg <= wide_sync_reg;
        end
    end

    // Direction register, all inputs after reset
    // Ignored for the data pins while slave mode owns them
    always_ff @(posedge I_MCLK) begin
        if (I_RESET) begin
            wide_dir_reg <= pdio_pkg::WIDE_DIR_RESET;
        end else if (i_WR && i_ADDR == pdio_pkg::WIDE_PORT_DIRECTION_OFS) begin
            wide_dir_reg <= i_WDATA;
        end
    end

    // ------------------------------------------------------------
    // Control port latches
    // ------------------------------------------------------------
    // Control output latch; seen only on pins set as outputs
    always_ff @(posedge I_MCLK) begin
        if (I_RESET) begin
            ctrl_out_reg <= pdio_pkg::CTRL_DATA_RESET;
        end else if (i_WR && i_ADDR == pdio_pkg::CONTROL_PORT_DATA_OFS) begin
            // Upper bits are dropped: only three pins exist
            ctrl_out_reg <=
                i_WDATA[pdio_pkg::CHIP_SELECT_IDX:pdio_pkg::READ_STROBE_IDX];
        end
    end

    // Analog configuration; reset leaves every control pin analog
    always_ff @(posedge I_MCLK) begin
        if (I_RESET) begin
            analog_cfg_reg <= pdio_pkg::ANALOG_CFG_RESET;
        end else if (i_WR && i_ADDR == pdio_pkg::ANALOG_PIN_CONFIG_OFS) begin
            analog_cfg_reg <= i_WDATA & pdio_pkg::ANALOG_CFG_MASK;
        end
    end

    assign ctrl_digital = analog_cfg_reg[pdio_pkg::ANALOG_DIGITAL_MSB:0];
    // Analog pins read zero. Only the read path is masked: the
    // strobe decode sees raw levels, so firmware must make the
    // pins digital before it enables slave mode.
    assign ctrl_read_val = ctrl_sync_reg & ctrl_digital;

    // ------------------------------------------------------------
    // Status/control register
    // ------------------------------------------------------------
    // Mode and control-pin directions
    // Writing the flag bits here has no effect except on overflow
    always_ff @(posedge I_MCLK) begin
        if (I_RESET) begin
            slave_mode_reg <= 1'b0;
            ctrl_dir_reg <= pdio_pkg::CTRL_DIR_RESET;
        end else if (cpu_stat_wr) begin
            slave_mode_reg <= i_WDATA[pdio_pkg::SLAVE_MODE_SELECT_BIT];
            ctrl_dir_reg <= i_WDATA[pdio_pkg::CTRL_DIR_MSB:0];
        end
    end

    // Input-full: set at end of a write, cleared in slave mode by a processor
    // read of the input latch; a set in the same cycle wins
    // Leaving slave mode clears it before either event is seen
    always_ff @(posedge I_MCLK) begin
        if (I_RESET) begin
            input_full_reg <= 1'b0;
        end else if (!slave_mode_reg) begin
            input_full_reg <= 1'b0;
        end else if (write_done) begin
            input_full_reg <= 1'b1;
        end else if (cpu_wide_rd) begin
            input_full_reg <= 1'b0;
        end
    end

    // Output-full: set by firmware write, cleared when the master
    // starts a read; the firmware set wins a same-cycle clash
    // Cleared as the read starts, not as it ends
    always_ff @(posedge I_MCLK) begin
        if (I_RESET) begin
            output_full_reg <= 1'b0;
        end else if (!slave_mode_reg) begin
            output_full_reg <= 1'b0;
        end else if (cpu_wide_wr) begin
            output_full_reg <= 1'b1;
        end else if (read_start) begin
            output_full_reg <= 1'b0;
        end
    end

    // Overflow: sticky, survives leaving slave mode, software clears
    // by writing zero; a new overflow beats the clear
    // Writing one sets it, which lets firmware test the flag path
    always_ff @(posedge I_MCLK) begin
        if (I_RESET) begin
            overflow_reg <= 1'b0;
        end else if (write_done && input_full_reg) begin
            overflow_reg <= 1'b1;
        end else if (cpu_stat_wr) begin
            overflow_reg <= i_WDATA[pdio_pkg::INPUT_OVERFLOW_BIT];
        end
    end

    // Assembled view; bit 3 is unimplemented
    always_comb begin
        status_val = 8'h00;
        status_val[pdio_pkg::INPUT_FULL_BIT] = input_full_reg;
        status_val[pdio_pkg::OUTPUT_FULL_BIT] = output_full_reg;
        status_val[pdio_pkg::INPUT_OVERFLOW_BIT] = overflow_reg;
        status_val[pdio_pkg::SLAVE_MODE_SELECT_BIT] = slave_mode_reg;
        status_val[pdio_pkg::CTRL_DIR_MSB:0] = ctrl_dir_reg;
    end

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    // Answer in the cycle after the strobe; unmapped reads return 0
    // Returning zero between reads keeps a stale answer from looking
    // valid to a master that samples late
    always_ff @(posedge I_MCLK) begin
        if (I_RESET) begin
            rdata_reg <= 8'h00;
        end else if (i_RD) begin
            unique case (i_ADDR)
                pdio_pkg::WIDE_PORT_DATA_OFS: begin
                    if (slave_mode_reg) begin
                        rdata_reg <= wide_in_reg;
                    end else begin
                        rdata_reg <= wide_sync_reg;
                    end
                end
                pdio_pkg::CONTROL_PORT_DATA_OFS: begin
                    rdata_reg <= {5'h00, ctrl_read_val};
                end
                pdio_pkg::WIDE_PORT_DIRECTION_OFS: begin
                    rdata_reg <= wide_dir_reg;
                end
                pdio_pkg::SLAVE_PORT_STATUS_CONTROL_OFS: begin
                    rdata_reg <= status_val;
                end
                pdio_pkg::ANALOG_PIN_CONFIG_OFS: begin
                    rdata_reg <= analog_cfg_reg;
                end
                default: begin
                    rdata_reg <= 8'h00;
                end
            endcase
        end else begin
            rdata_reg <= 8'h00;
        end
    end

    assign o_RDATA = rdata_reg;

    // ------------------------------------------------------------
    // Pin drivers
    // ------------------------------------------------------------
    // Slave mode ignores the direction register: the external master
    // owns the bus direction and only a selected read drives it
    always_comb begin
        if (slave_mode_reg) begin
            o_WIDE_OE = {8{rd_active}};
        end else begin
            o_WIDE_OE = ~wide_dir_reg;
        end
    end

    // Output latch drives the data pins in both modes
    // In slave mode this is the byte the external master reads;
    // firmware writes to it also raise output-full
    assign o_WIDE_PIN = wide_out_reg;

    // Control drivers obey direction even as analog inputs or strobes
    // A pin set as output while used as a strobe fights the master,
    // so firmware must keep all three as inputs in slave mode
    assign o_CTRL_OE = ~ctrl_dir_reg;
    assign o_CTRL_PIN = ctrl_out_reg;

endmodule : parallel_port_d_e_io

`default_nettype wire

// [pdio_props.sv]
// Port checks for the two-port parallel I/O block with slave port.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none

module pdio_props (
    // Clock and reset
    input wire logic I_MCLK,
    input wire logic I_RESET,
    // Register bus
    input wire logic [7:0] i_ADDR,
    input wire logic [7:0] i_WDATA,
    input wire logic i_WR,
    input wire logic i_RD,
    input wire logic [7:0] o_RDATA,
    // Pins
    input wire logic [7:0] i_WIDE_PIN,
    input wire logic [7:0] o_WIDE_PIN,
    input wire logic [7:0] o_WIDE_OE,
    input wire logic [2:0] i_CTRL_PIN,
    input wire logic [2:0] o_CTRL_PIN,
    input wire logic [2:0] o_CTRL_OE
);
    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking @(posedge I_MCLK); endclocking
    default disable iff (I_RESET);
    logic mode_reg;

    // Shadow of the mode bit, so pin checks know the port's role
    always_ff @(posedge I_MCLK) begin
        if (I_RESET) begin
            mode_reg <= 1'b0;
        end else if (i_WR && i_ADDR == 8'h89) begin
            mode_reg <= i_WDATA[4];
        end
    end

    a_rdata_quiet: assert property (!$past(i_RD) |-> o_RDATA == 8'h00)
        else $error("read data not zero outside read slot");
    a_reset_dirs: assert property ($fell(I_RESET) |->
        o_WIDE_OE == 8'h00 && o_CTRL_OE == 3'h0)
        else $error("pins driven after reset");
    a_bit3_zero: assert property (i_RD && i_ADDR == 8'h89 |=> !o_RDATA[3])
        else $error("status bit 3 not zero");
    a_ctrl_upper: assert property (i_RD && i_ADDR == 8'h09 |=> o_RDATA[7:3] == 5'h00)
        else $error("control data upper bits not zero");
    a_ctrl_dir: assert property (i_WR && i_ADDR == 8'h89 |=>
        o_CTRL_OE == ~$past(i_WDATA[2:0]))
        else $error("control drive enable wrong");
    a_wide_dir: assert property (!mode_reg && i_WR && i_ADDR == 8'h88 |=>
        o_WIDE_OE == ~$past(i_WDATA))
        else $error("wide drive enable wrong");
    a_wide_latch: assert property (i_WR && i_ADDR == 8'h08 |=>
        o_WIDE_PIN == $past(i_WDATA))
        else $error("wide output latch wrong");
    a_ctrl_latch: assert property (i_WR && i_ADDR == 8'h09 |=>
        o_CTRL_PIN == $past(i_WDATA[2:0]))
        else $error("control output latch wrong");
    // Sync lag is two edges, so three samples of a steady strobe suffice
    a_slave_drive: assert property ((mode_reg && i_CTRL_PIN == 3'b010) [*3] |->
        o_WIDE_OE == 8'hff)
        else $error("slave read not driving data");
    a_desel_quiet: assert property ((mode_reg && i_CTRL_PIN[2]) [*3] |->
        o_WIDE_OE == 8'h00)
        else $error("deselected port driving data");

    c_slave_read: cover property ((mode_reg && i_CTRL_PIN == 3'b010) [*3]);
    c_slave_write: cover property ((mode_reg && i_CTRL_PIN == 3'b001) [*3]);
    c_status_full: cover property (i_RD && i_ADDR == 8'h89 ##1 o_RDATA[7]);
endmodule : pdio_props

`default_nettype wire

// [pdio_master.sv]
// External 8-bit processor driving the slave-port strobes and data.
// Assumes the bench resolves the shared data lines from both enables.
`timescale 1ns/1ps
`default_nettype none

module pdio_master (
    // Pacing clock
    input wire logic clk,
    input wire logic [7:0] bus,
    // Strobes [0] read, [1] write, [2] select, all active low
    output logic [2:0] ctrl_n,
    output logic [7:0] d_out,
    output logic d_oe
);
    // ------------------------------------------------------------
    // Bus cycles
    // ------------------------------------------------------------
    initial begin
        ctrl_n = 3'h7;
        d_out = 8'h00;
        d_oe = 1'b0;
    end

    // Plain pin drive for ordinary I/O mode
    task automatic drive(input logic [7:0] d);
        @(posedge clk);
        d_out <= d;
        d_oe <= 1'b1;
    endtask : drive

    // Data held two cycles past the strobe to cover the device's sync lag
    task automatic wr_byte(input logic [7:0] d, input logic sel);
        @(posedge clk);
        d_out <= d;
        d_oe <= 1'b1;
        ctrl_n <= {~sel, 1'b0, 1'b1};
        repeat (4) @(posedge clk);
        ctrl_n <= 3'h7;
        repeat (2) @(posedge clk);
        d_oe <= 1'b0;
        repeat (4) @(posedge clk);
    endtask : wr_byte

    // Read with the given select level, data taken before the strobe rises
    task automatic rd_byte(output logic [7:0] got, input logic sel);
        @(posedge clk);
        ctrl_n <= {~sel, 1'b1, 1'b0};
        repeat (4) @(posedge clk);
        got = bus;
        ctrl_n <= 3'h7;
        repeat (4) @(posedge clk);
    endtask : rd_byte
endmodule : pdio_master

`default_nettype wire

// [parallel_port_d_e_io_tb_top.sv]
// Self-checking bench for the two-port parallel I/O block.
// Assumes the checker and the external master model are compiled first.
`timescale 1ns/1ps
`default_nettype none

module parallel_port_d_e_io_tb_top;
    // ------------------------------------------------------------
    // Clock, bus and pin wiring
    // ------------------------------------------------------------
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] flt = 8'h96;
    logic [7:0] rdata, wpin_o, woe, m_d;
    logic [2:0] cpin_o, coe, m_ctrl;
    logic m_oe;
    wire [7:0] wide;
    wire [2:0] ctrl;
    int error_cnt = 0;
    int n_checks = 0;

    // Undriven data lines toggle so a stale value never passes
    always @(posedge clk) flt <= ~flt;
    assign wide = (woe & wpin_o) | (~woe & (m_oe ? m_d : flt));
    assign ctrl = (coe & cpin_o) | (~coe & m_ctrl);

    initial begin
        forever #10 clk = ~clk;
    end

    parallel_port_d_e_io dut (.I_MCLK(clk), .I_RESET(rst), .i_ADDR(addr), .i_WDATA(wdata),
        .i_WR(wr), .i_RD(rd), .o_RDATA(rdata), .i_WIDE_PIN(wide), .o_WIDE_PIN(wpin_o),
        .o_WIDE_OE(woe), .i_CTRL_PIN(ctrl), .o_CTRL_PIN(cpin_o), .o_CTRL_OE(coe));
    pdio_master u_m (.clk(clk), .bus(wide), .ctrl_n(m_ctrl), .d_out(m_d), .d_oe(m_oe));

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic wreg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wreg

    // Read data stand only in the cycle after the strobe
    task automatic rreg(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        chk($sformatf("reg %h", a), exp, rdata);
    endtask : rreg

    task automatic t_reset;
        rreg(8'h89, 8'h07);
        rreg(8'h88, 8'hff);
        rreg(8'h09, 8'h00);
        rreg(8'h9f, 8'h00);
        rreg(8'h55, 8'h00);
        chk("wide oe", 8'h00, woe);
        $display("test reset done");
    endtask : t_reset

    task automatic t_io;
        u_m.drive(8'h3c);
        wreg(8'h88, 8'h0f);
        wreg(8'h08, 8'ha5);
        repeat (3) @(negedge clk);
        chk("wide oe", 8'hf0, woe);
        chk("wide latch", 8'ha5, wpin_o);
        rreg(8'h08, 8'hac);
        wreg(8'h9f, 8'hff);
        rreg(8'h9f, 8'hcf);
        wreg(8'h89, 8'h0e);
        wreg(8'h09, 8'hfe);
        repeat (3) @(negedge clk);
        chk("ctrl oe", 8'h01, {5'h00, coe});
        rreg(8'h09, 8'h06);
        rreg(8'h89, 8'h06);
        wreg(8'h9f, 8'h00);
        repeat (3) @(negedge clk);
        chk("ctrl oe", 8'h01, {5'h00, coe});
        rreg(8'h09, 8'h00);
        wreg(8'h89, 8'h07);
        $display("test port io done");
    endtask : t_io

    task automatic t_slave;
        logic [7:0] got;
        wreg(8'h9f, 8'h07);
        wreg(8'h89, 8'h17);
        u_m.wr_byte(8'h11, 1'b0);
        rreg(8'h89, 8'h17);
        u_m.wr_byte(8'h3c, 1'b1);
        rreg(8'h89, 8'h97);
        u_m.wr_byte(8'hc3, 1'b1);
        rreg(8'h89, 8'hb7);
        rreg(8'h08, 8'hc3);
        rreg(8'h89, 8'h37);
        wreg(8'h89, 8'h17);
        rreg(8'h89, 8'h17);
        wreg(8'h08, 8'h5a);
        rreg(8'h89, 8'h57);
        u_m.rd_byte(got, 1'b0);
        rreg(8'h89, 8'h57);
        u_m.rd_byte(got, 1'b1);
        chk("slave read data", 8'h5a, got);
        rreg(8'h89, 8'h17);
        u_m.wr_byte(8'h99, 1'b1);
        wreg(8'h89, 8'h27);
        rreg(8'h89, 8'h27);
        wreg(8'h89, 8'h07);
        $display("test slave port done");
    endtask : t_slave

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : report_and_stop

    // ------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_io();
        t_slave();
        report_and_stop();
    end

    // Whole run needs well under a thousand cycles
    initial begin
        repeat (3000) @(posedge clk);
        error_cnt++;
        report_and_stop();
    end
endmodule : parallel_port_d_e_io_tb_top

bind parallel_port_d_e_io pdio_props u_props (.I_MCLK(I_MCLK), .I_RESET(I_RESET),
    .i_ADDR(i_ADDR), .i_WDATA(i_WDATA), .i_WR(i_WR), .i_RD(i_RD), .o_RDATA(o_RDATA),
    .i_WIDE_PIN(i_WIDE_PIN), .o_WIDE_PIN(o_WIDE_PIN), .o_WIDE_OE(o_WIDE_OE),
    .i_CTRL_PIN(i_CTRL_PIN), .o_CTRL_PIN(o_CTRL_PIN), .o_CTRL_OE(o_CTRL_OE));

`default_nettype wire
